// file: rtl/adc_host_interface_control.sv
// Purpose: host-side control of a 12-bit successive-approximation converter
// Assumes: control pins synchronous to clk, comparator sampled each step
// Notes:   data pins are two signals: out, enable (high = driving)
//
// Behaviour
// (RULE1) start captures short-cycle select: high means 8 bits
// (RULE2) 8-bit result reads with four low bits zero
// (RULE3) only short-cycle select is latched
// (RULE4) start on last of enable, select, convert
// (RULE5) disabled chip neither starts nor drives
// (RULE6) simultaneous changes start with same delay
// (RULE7) host settles other inputs 50 ns ahead
// (RULE8) status high exactly during conversion
// (RULE9) outputs high impedance while status high
// (RULE10) starts ignored during a conversion
// (RULE11) start during conversion recaptures short-cycle select
// (RULE12) drive only when read, idle, enabled, selected
// (RULE13) twelve-bit read drives all lines, ignores address
// (RULE14) byte read: address low MSBs, high LSBs+zeros
// (RULE15) never both bytes; address toggle harmless
// (RULE16) read/convert rising begins a result read
// (RULE17) host drives byte address from address LSB
// (RULE18) status drops after result is latched
// (RULE19) conversion plus reacquire within 25 us
// (RULE20) one result bit per internal clock step
`timescale 1ns/10ps
module adc_host_interface_control #(
    parameter int RES_BITS   = conv_ctrl_pkg::RES_W,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic                       clk_en,
    input  wire conv_ctrl_pkg::ctrl_pins_s  ctrl_pins,
    input  wire logic                       comp_above,
    output logic                            sample_hold,
    output logic [RES_BITS-1:0]             dac_trial,
    output logic                            busy_status_out,
    output logic [RES_BITS-1:0]             result_data_lines,
    output logic [RES_BITS-1:0]             result_data_oe,
    output logic                            read_begin
);
    // ************************************************************
    // pin decode
    // ************************************************************
    conv_ctrl_pkg::ctrl_pins_s prev_pins_reg;   // pins one clock ago
    conv_ctrl_pkg::conv_state_e state_reg;      // sequencer state
    conv_ctrl_pkg::conv_state_e state_next;     // sequencer next state
    logic [RES_BITS-1:0]              sar_reg;          // trial code
    logic [RES_BITS-1:0]              bit_reg;          // bit under test
    logic [conv_ctrl_pkg::STEP_CNT_W-1:0] step_reg;    // steps done
    logic                             short_reg;        // captured length
    logic [RES_BITS-1:0]              out_reg;          // output register
    logic                             out_short_reg;    // length of out_reg
    logic                             fifo_in_ready;    // fifo can accept
    logic                             fifo_out_valid;   // result waiting
    conv_ctrl_pkg::result_s           fifo_out;         // waiting result
    conv_ctrl_pkg::result_s           fifo_in;          // finished result

    // start qualifier level
    function automatic logic start_level(input conv_ctrl_pkg::ctrl_pins_s p);
        start_level = p.chip_en && !p.chip_sel_n && !p.read_conv;
    endfunction : start_level

    // qualifier became true this clock, whichever input closed it
    wire start_edge  = start_level(ctrl_pins) && !start_level(prev_pins_reg); // RULE4 RULE6
    wire chip_active = ctrl_pins.chip_en && !ctrl_pins.chip_sel_n;            // RULE5
    wire busy        = state_reg != conv_ctrl_pkg::ST_IDLE;
    wire step_last   = step_reg == (short_reg ? conv_ctrl_pkg::STEPS_SHORT
                                              : conv_ctrl_pkg::STEPS_FULL) - 1'b1; // RULE20
    // status still high while the result drains: starts stay refused
    wire take_start  = start_edge && !busy && !busy_status_out;               // RULE10
    wire can_store   = state_reg == conv_ctrl_pkg::ST_LATCH && fifo_in_ready;
    wire read_en     = chip_active && ctrl_pins.read_conv && !busy_status_out; // RULE12 RULE9
    wire sel_high    = !ctrl_pins.width_12 && !ctrl_pins.byte_addr_short_cycle; // RULE14
    wire sel_low     = !ctrl_pins.width_12 && ctrl_pins.byte_addr_short_cycle;  // RULE15

    assign fifo_in.code        = sar_reg;
    assign fifo_in.short_cycle = short_reg;
    assign dac_trial           = sar_reg | bit_reg;
    assign sample_hold         = busy;     // tracks once the latch state is left and the state is idle; RULE19
    assign read_begin          = chip_active && ctrl_pins.read_conv
                                 && !prev_pins_reg.read_conv;  // RULE16

    // ************************************************************
    // sequencer
    // ************************************************************
    // next state selection
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            conv_ctrl_pkg::ST_IDLE:
                if (take_start) state_next = conv_ctrl_pkg::ST_STEP;
            conv_ctrl_pkg::ST_STEP:
                if (step_last) state_next = conv_ctrl_pkg::ST_LATCH;
            conv_ctrl_pkg::ST_LATCH:
                if (can_store) state_next = conv_ctrl_pkg::ST_IDLE;
            default:
                state_next = conv_ctrl_pkg::ST_IDLE;
        endcase
    end

    // state, edge memory and length capture
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg     <= conv_ctrl_pkg::ST_IDLE;
            prev_pins_reg <= '0;
            short_reg     <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg     <= state_next;
            prev_pins_reg <= ctrl_pins;
            // any start edge recaptures, even mid conversion
            if (start_edge) short_reg <= ctrl_pins.byte_addr_short_cycle; // RULE1 RULE11 RULE3
        end
    end

    // successive approximation datapath
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sar_reg  <= conv_ctrl_pkg::RESULT_RST;
            bit_reg  <= conv_ctrl_pkg::RESULT_RST;
            step_reg <= '0;
        end
        else if (clk_en)
        begin
            if (take_start)
            begin
                sar_reg  <= conv_ctrl_pkg::RESULT_RST;
                bit_reg  <= {1'b1, {(RES_BITS-1){1'b0}}};
                step_reg <= '0;
            end
            else if (state_reg == conv_ctrl_pkg::ST_STEP)
            begin
                // keep the trial bit if input sits above it
                if (comp_above) sar_reg <= sar_reg | bit_reg; // RULE20
                bit_reg  <= bit_reg >> 1;
                step_reg <= step_reg + 1'b1;
            end
        end
    end

    // ************************************************************
    // result buffer and output register
    // ************************************************************
    result_fifo #(
        .WIDTH (RES_BITS + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (clk_en),
        .in_valid  (state_reg == conv_ctrl_pkg::ST_LATCH),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out)
    );

    // output register loads; status falls on the same edge that loads the result
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_reg         <= conv_ctrl_pkg::RESULT_RST;
            out_short_reg   <= 1'b0;
            busy_status_out <= 1'b0;
        end
        else if (clk_en)
        begin
            if (fifo_out_valid)
            begin
                out_reg       <= fifo_out.code;
                out_short_reg <= fifo_out.short_cycle;
            end
            busy_status_out <= take_start || (busy_status_out
                               && !(fifo_out_valid && !busy)); // RULE8 RULE18
        end
    end

    // ************************************************************
    // three-state data lines
    // ************************************************************
    wire [RES_BITS-1:0] low_mask = out_short_reg
                                   ? {{(RES_BITS-conv_ctrl_pkg::LOW_NIB_W){1'b1}},
                                      {conv_ctrl_pkg::LOW_NIB_W{1'b0}}}
                                   : {RES_BITS{1'b1}};
    wire [RES_BITS-1:0] shown    = out_reg & low_mask;    // RULE2
    wire [RES_BITS-1:0] full_val = shown;                 // RULE13
    wire [RES_BITS-1:0] hi_byte  = {{(RES_BITS-conv_ctrl_pkg::BYTE_W){1'b0}},
                                    shown[RES_BITS-1 -: conv_ctrl_pkg::BYTE_W]};
    wire [RES_BITS-1:0] lo_byte  = {{(RES_BITS-conv_ctrl_pkg::BYTE_W){1'b0}},
                                    shown[conv_ctrl_pkg::LOW_NIB_W-1:0],
                                    {conv_ctrl_pkg::LOW_NIB_W{1'b0}}};
    wire [RES_BITS-1:0] byte_oe  = {{(RES_BITS-conv_ctrl_pkg::BYTE_W){1'b0}},
                                    {conv_ctrl_pkg::BYTE_W{1'b1}}};

    assign result_data_lines = ctrl_pins.width_12 ? full_val
                             : (sel_low ? lo_byte : hi_byte);   // RULE14 RULE15
    assign result_data_oe    = !read_en ? '0
                             : (ctrl_pins.width_12 ? {RES_BITS{1'b1}}
                             : ((sel_high || sel_low) ? byte_oe : '0)); // RULE5 RULE12

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !clk_en);

    chk_oe_when_busy: assert property (busy_status_out |-> result_data_oe == '0) // RULE9
        else $error("data driven during conversion");
    chk_start_raises: assert property (take_start |=> busy_status_out) // RULE8
        else $error("status not raised by start");
    chk_no_restart: assert property (busy && start_edge |=> step_reg != '0
                                     || state_reg != conv_ctrl_pkg::ST_STEP) // RULE10
        else $error("conversion restarted");
    chk_disabled_quiet: assert property (!chip_active |-> result_data_oe == '0
                                         && !take_start) // RULE5
        else $error("disabled chip acted");
    chk_short_capture: assert property (start_edge |=> short_reg ==
                                        $past(ctrl_pins.byte_addr_short_cycle)) // RULE1
        else $error("length not captured");
    chk_low_zero: assert property (out_short_reg && ctrl_pins.width_12
                                   |-> result_data_lines[3:0] == 4'h0) // RULE2
        else $error("low nibble not zero");
    chk_byte_zeros: assert property (sel_low |-> result_data_lines[3:0] == 4'h0) // RULE14
        else $error("low byte tail not zero");
    chk_status_len: assert property (take_start && !ctrl_pins.byte_addr_short_cycle
                                     |=> busy_status_out [*8]) // RULE8
        else $error("status dropped early");
    chk_enable_full: assert property (read_en && ctrl_pins.width_12
                                      |-> result_data_oe == {RES_BITS{1'b1}}) // RULE12
        else $error("read not enabled");
    chk_status_falls: assert property (busy_status_out && !busy && fifo_out_valid
                                       |=> !busy_status_out ##0 out_reg == $past(fifo_out.code)) // RULE18
        else $error("status fell before latch");

    cov_full_conv: cover property (take_start ##[1:30] $fell(busy_status_out));
    cov_short_conv: cover property (take_start && ctrl_pins.byte_addr_short_cycle);
    cov_byte_read: cover property (read_en && sel_low);
    cov_ignored: cover property (busy && start_edge);
endmodule : adc_host_interface_control

// file: rtl/conv_ctrl_pkg.sv
// Purpose: shared constants and types for the converter host interface
// Assumes: 20 MHz clock, synchronous control inputs
// Notes:   timing counts are derived from times printed in ns and us
package conv_ctrl_pkg;

    // ************************************************************
    // widths and timing
    // ************************************************************
    localparam int RES_W          = 12;            // full result width
    localparam int BYTE_W         = 8;             // byte width on a narrow bus
    localparam int SHORT_BITS     = 8;             // short-cycle length
    localparam int LOW_NIB_W      = 4;             // forced-zero nibble width
    localparam int CLK_PERIOD_NS  = 50;            // clock period
    localparam int THROUGHPUT_NS  = 25000;         // conversion plus reacquire
    // longest time: rounds down
    localparam int THROUGHPUT_CYC = THROUGHPUT_NS / CLK_PERIOD_NS;
    localparam int ACQ_CYC        = THROUGHPUT_CYC - RES_W - 2; // tracking budget
    localparam int STEP_CNT_W     = 4;             // step counter width
    localparam logic [STEP_CNT_W-1:0] STEPS_FULL  = 4'hC;
    localparam logic [STEP_CNT_W-1:0] STEPS_SHORT = 4'h8;
    localparam logic [RES_W-1:0]      RESULT_RST  = 12'h0_000;
    localparam logic [BYTE_W-1:0]     BYTE_ZERO   = 8'h00;

    // ************************************************************
    // state machine and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_STEP  = 2'b01,
        ST_LATCH = 2'b10
    } conv_state_e;

    // control pins taken together
    typedef struct packed {
        logic chip_en;        // active high enable
        logic chip_sel_n;     // active low select
        logic read_conv;      // 1 read, 0 convert
        logic width_12;       // 1 twelve-bit read, 0 byte read
        logic byte_addr_short_cycle;
    } ctrl_pins_s;

    // one finished conversion on its way to the output register
    typedef struct packed {
        logic [RES_W-1:0] code;
        logic             short_cycle;
    } result_s;

endpackage : conv_ctrl_pkg

// file: rtl/result_fifo.sv
// Purpose: small valid/ready FIFO between the sequencer and the output register
// Assumes: single clock, clock enable freezes all state
// Notes:   full and empty are exact; depth must be a power of two
`timescale 1ns/10ps
module result_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ************************************************************
    // storage and pointers
    // ************************************************************
    logic [WIDTH-1:0] mem_reg [DEPTH];   // word store
    logic [AW:0]      wr_ptr_reg;        // write pointer, extra wrap bit
    logic [AW:0]      rd_ptr_reg;        // read pointer, extra wrap bit
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

    // pointer update
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else if (ce)
        begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // data write, no reset needed
    always_ff @(posedge clk)
    begin
        if (ce && push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
endmodule : result_fifo

// file: testbench/analog_front_model.sv
// Purpose: comparator and held input level in front of the converter block
// Assumes: level is given in whole codes, the analog input sits half a code above it
// Notes:   the half-code offset keeps the trial equal to the level on the kept side
`timescale 1ns/10ps
module analog_front_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sample_hold,
    input  wire logic [11:0] dac_trial,
    input  wire logic [11:0] level,
    output logic             comp_above
);
    logic [11:0] held_reg;  // level frozen while holding

    // track the input while not holding
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            held_reg <= 12'h0_000;
        else if (!sample_hold)
            held_reg <= level;
    end

    // input is above the trial whenever the trial does not exceed the level
    assign comp_above = (dac_trial <= held_reg);
endmodule : analog_front_model

// file: testbench/tb_adc_host_interface_control.sv
// Purpose: self-checking bench for the converter host interface
// Assumes: pins change by non-blocking assignment at the rising edge
// Notes:   busy run length is measured by a monitor at each falling edge
`timescale 1ns/10ps
module tb_adc_host_interface_control;
    logic                      clk;
    logic                      rstn;
    conv_ctrl_pkg::ctrl_pins_s pins;        // control pins driven by the bench
    logic                      comp;        // comparator answer
    logic                      sh;          // holding flag
    logic [11:0]               trial;       // trial code
    logic                      busy;        // status output
    logic [11:0]               data;        // result lines
    logic [11:0]               oe;          // per-line drive enable
    logic                      rbeg;        // read start pulse
    logic [11:0]               level;       // analog level in codes
    int                        num_errors;
    int                        checked;
    int                        run_cnt;     // cycles of the running busy phase
    int                        last_len;    // length of the last busy phase
    int                        rb_cnt;      // read start pulses seen
    int                        cyc;         // cycle counter for the timeout

    // ************************************************************
    // clock, design and partner
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    adc_host_interface_control DUT (.clk(clk), .rstn(rstn), .clk_en(1'b1), .ctrl_pins(pins),
        .comp_above(comp), .sample_hold(sh), .dac_trial(trial), .busy_status_out(busy),
        .result_data_lines(data), .result_data_oe(oe), .read_begin(rbeg));

    analog_front_model front (.clk(clk), .rstn(rstn), .sample_hold(sh), .dac_trial(trial),
        .level(level), .comp_above(comp));

    // ************************************************************
    // monitors and timeout
    // ************************************************************
    // sampled at the falling edge, away from the launching edge
    always @(negedge clk)
    begin
        if (busy === 1'b1)
            run_cnt <= run_cnt + 1;
        else
        begin
            if (run_cnt != 0)
                last_len <= run_cnt;
            run_cnt <= 0;
        end
        if (rbeg === 1'b1)
            rb_cnt <= rb_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic set_pins(input logic [4:0] p);
        @(posedge clk);
        pins <= p;
    endtask : set_pins

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // wait for busy to drop, then let the monitor record the length
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 60)
        begin
            @(negedge clk);
            n = n + 1;
        end
        repeat (2) @(negedge clk);
    endtask : wait_idle

    // pre-state by kind, held two cycles, then the start level
    task automatic convert(input int kind, input logic a0, input logic [11:0] len);
        logic [2:0] pre;
        pre = (kind == 0) ? 3'b000 : (kind == 1) ? 3'b110 : (kind == 2) ? 3'b101 : 3'b011;
        set_pins({pre, 1'b1, a0});
        set_pins({pre, 1'b1, a0});
        set_pins({3'b100, 1'b1, a0});
        @(negedge clk);
        chk({11'h000, busy}, 12'h0_000);
        @(negedge clk);
        chk({11'h000, busy}, 12'h0_001);
        wait_idle();
        chk(12'(last_len), len);
    endtask : convert

    // read with width select and address, compare enables and driven data
    task automatic read(input logic w, input logic a, input logic [11:0] eo,
                        input logic [11:0] ed);
        int rb0;
        rb0 = rb_cnt;
        set_pins({3'b101, w, a});
        repeat (2) @(negedge clk);
        chk(oe, eo);
        chk(data & oe, ed);
        chk(12'(rb_cnt - rb0), 12'h0_001);
        set_pins({3'b110, w, a});                    // deselect, no convert edge
    endtask : read

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // ************************************************************
    // test sequence
    // ************************************************************
    initial
    begin
        logic [11:0] v;
        rstn = 1'b0;
        pins = 5'b01110;
        level = 12'h0_000;
        num_errors = 0;
        checked = 0;
        run_cnt = 0;
        last_len = 0;
        rb_cnt = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({11'h000, busy}, 12'h0_000);
        chk(oe, 12'h0_000);
        $display("test reset done");
        // every start kind, full length, every read format
        for (int k = 0; k < 4; k++)
        begin
            v = 12'h0_A5C + 12'(k * 12'h0_111);
            level = v;
            convert(k, 1'b0, 12'h0_00E);
            read(1'b1, 1'b1, 12'h0_FFF, v);
            for (int addr = 0; addr < 2; addr++)
            begin
                read(1'b0, addr[0], 12'h0_0FF,
                     addr[0] ? {4'h0, v[3:0], 4'h0} : {4'h0, v[11:4]});
            end
        end
        $display("test start kinds done");
        // short cycle: low nibble reads zero
        level = 12'h0_7E9;
        convert(2, 1'b1, 12'h0_00A);
        read(1'b1, 1'b0, 12'h0_FFF, 12'h0_7E0);
        $display("test short cycle done");
        // disabled chip: convert falling edge does nothing
        set_pins(5'b00110);
        set_pins(5'b00010);
        repeat (20) @(negedge clk);
        chk({11'h000, busy}, 12'h0_000);
        set_pins(5'b11110);
        repeat (2) @(negedge clk);
        chk(oe, 12'h0_000);
        $display("test disabled done");
        // start during conversion: ignored, short-cycle bit recaptured
        level = 12'h0_3C6;
        set_pins(5'b10110);
        set_pins(5'b10010);
        set_pins(5'b10110);
        @(negedge clk);
        chk(oe, 12'h0_000);
        set_pins(5'b10011);
        set_pins(5'b10111);
        @(negedge clk);
        while (busy === 1'b1 && cyc < 19000)
            @(negedge clk);
        chk(oe, 12'h0_FFF);
        chk(data, 12'h0_3C0);
        repeat (2) @(negedge clk);
        chk(12'(last_len), 12'h0_00A);
        $display("test busy restart done");
        // byte address acts directly with width select held low, address toggles every two cycles
        for (int i = 0; i < 6; i++)
        begin
            set_pins({3'b101, 1'b0, i[0]});
            @(negedge clk);
            @(negedge clk);
            chk(oe, 12'h0_0FF);
            chk(data & oe, i[0] ? 12'h0_000 : 12'h0_03C);
        end
        $display("test byte toggle done");
        print_verdict();
    end
endmodule : tb_adc_host_interface_control
